// *** hdl/sar_pkg.sv ***
// Function
// - fifteen stages hold address through reference
// - low seven stages count down as shifter
// - loads only set stages to one
// - three load strobes, one per counter
// - sends contents back to program counter
// - address selects one storage location
// - gate passes strobe only with source one
// - strobe ORs contents into exchange low stages
// - clear request zeros every stage
// - start preset gives zero or octal 40001
// - unassigned address raises class fault, halts
package sar_pkg;
    // register width
    localparam int ADDR_W = 15;
    // shift counter width in the low stages
    localparam int SHIFT_W = 7;
    // value after reset
    localparam logic [14:0] RESET_VALUE = 15'h0000;
    // second drum address, octal 40001
    localparam logic [14:0] DRUM_START = 15'h4001;
    // top field positions for class decode
    localparam int TOP3_LSB = 12;
    localparam int TOP6_LSB = 9;
    // storage class codes, one-hot
    typedef enum logic [4:0] {
        SAR_CLASS_NONE = 5'h01,
        SAR_CLASS_CORE = 5'h02,
        SAR_CLASS_DRUM = 5'h04,
        SAR_CLASS_Q = 5'h08,
        SAR_CLASS_ACC = 5'h10
    } sar_class_t;
    // whole block state
    typedef struct packed {
        logic [14:0] addr;
        logic fault;
    } sar_state_t;
endpackage : sar_pkg

// *** hdl/sar_storage_address_register.sv ***
`timescale 1ns/1ns
module sar_storage_address_register (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // counter sources and load strobes
    input wire logic [14:0] i_program_address_counter,
    input wire logic [14:0] i_first_operand_counter,
    input wire logic [14:0] i_second_operand_counter,
    input wire logic i_program_counter_load_strobe,
    input wire logic i_first_operand_load_strobe,
    input wire logic i_second_operand_load_strobe,
    // clear and start preset
    input wire logic i_address_register_clear,
    input wire logic i_start_preset,
    input wire logic i_start_select_drum,
    // shift counter control from arithmetic section
    input wire logic i_shift_count_strobe,
    // outbound transfer strobes
    input wire logic i_to_program_counter_strobe,
    input wire logic i_to_exchange_strobe,
    // outputs
    output logic [14:0] o_address,
    output logic [14:0] o_program_counter_set,
    output logic [14:0] o_exchange_set,
    output logic [6:0] o_shift_counter,
    output logic [4:0] o_storage_class,
    output logic o_class_fault
);
    // all state lives in one packed struct; the flop copy and the next copy
    // keep the address and the sticky fault in step with each other
    sar_pkg::sar_state_t state_reg; // registered state
    sar_pkg::sar_state_t state_next; // value for the next edge
    // gated ones from all three sources, merged before they reach the stages
    logic [14:0] set_mask; // ones to OR in from gated sources
    // the decode only ever looks at the leading octal digits
    logic [2:0] top3; // leading octal digit
    logic [5:0] top6; // two leading octal digits
    // one-hot storage class of the current address
    sar_pkg::sar_class_t class_dec;

    // one gate per stage per source; strobe passes only with source one
    // a gate can only drive its stage to one, never to zero, so several
    // strobes in one cycle simply merge; the controller must clear first
    // if it wants a plain copy rather than a merge of old and new ones
    always_comb begin
        for (int i = 0; i < sar_pkg::ADDR_W; i++) begin
            set_mask[i] = (i_program_counter_load_strobe & i_program_address_counter[i])
                | (i_first_operand_load_strobe & i_first_operand_counter[i])
                | (i_second_operand_load_strobe & i_second_operand_counter[i]);
        end
    end

    // storage class decode by octal ranges
    // core takes the two lowest octal groups, Q and the accumulator a
    // whole leading digit each, and drum the upper half of the space;
    // the remaining gaps are unassigned and must stop the machine
    assign top3 = state_reg.addr[14:sar_pkg::TOP3_LSB];
    assign top6 = state_reg.addr[14:sar_pkg::TOP6_LSB];
    always_comb begin
        class_dec = sar_pkg::SAR_CLASS_NONE;
        if (top6 == 6'h00 || top6 == 6'h01) begin
            class_dec = sar_pkg::SAR_CLASS_CORE;
        end else if (top3 == 3'h1) begin
            class_dec = sar_pkg::SAR_CLASS_Q;
        end else if (top3 == 3'h2) begin
            class_dec = sar_pkg::SAR_CLASS_ACC;
        end else if (top3[2]) begin
            class_dec = sar_pkg::SAR_CLASS_DRUM;
        end else begin
            class_dec = sar_pkg::SAR_CLASS_NONE;
        end
    end

    // next state: clear and preset beat loads; loads only OR in ones
    // clear wins so that a late strobe from the previous reference
    // cannot leak stale ones into the address of the next reference;
    // the shift decrement acts after the OR so both land in one edge
    always_comb begin
        state_next = state_reg;
        if (i_address_register_clear) begin
            state_next.addr = sar_pkg::RESET_VALUE;
        end else if (i_start_preset) begin
            // drum choice sets top and bottom stages, rest zero
            state_next.addr = i_start_select_drum ? sar_pkg::DRUM_START : sar_pkg::RESET_VALUE;
        end else begin
            state_next.addr = state_reg.addr | set_mask;
            if (i_shift_count_strobe) begin
                // only the low stages count; no borrow into the high stages
                state_next.addr[6:0] = state_next.addr[6:0] - 7'h01;
            end
        end
        // fault is sticky; it halts until reset
        // there is no software clear, so only a full reset restarts work
        if (class_dec == sar_pkg::SAR_CLASS_NONE) begin
            state_next.fault = 1'b1;
        end
    end

    // one register for the whole state, synchronous reset
    // reset leaves the first core address in place, a legal class,
    // so the fault cannot rise by itself straight after reset
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_reg <= '{addr: sar_pkg::RESET_VALUE, fault: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs; transfers out set only the ones, like the inbound gates
    // the send outputs are combinational so the receiver sees them in the
    // strobe cycle; they are zero outside it, which the receiver ORs harmlessly
    assign o_address = state_reg.addr;
    assign o_program_counter_set = i_to_program_counter_strobe ? state_reg.addr : 15'h0000;
    assign o_exchange_set = i_to_exchange_strobe ? state_reg.addr : 15'h0000;
    assign o_shift_counter = state_reg.addr[6:0];
    assign o_storage_class = class_dec;
    assign o_class_fault = state_reg.fault;

    a_clear_wins: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_address_register_clear |=> o_address == 15'h0000) else $error("clear did not zero");
    a_load_or: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_address_register_clear && !i_start_preset && !i_shift_count_strobe && i_program_counter_load_strobe
        && !i_first_operand_load_strobe && !i_second_operand_load_strobe)
        |=> o_address == ($past(o_address) | $past(i_program_address_counter))) else $error("load not OR");
    a_hold_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_address_register_clear && !i_start_preset && !i_shift_count_strobe && set_mask == 15'h0000)
        |=> $stable(o_address)) else $error("address changed idle");
    a_preset_drum: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_address_register_clear && i_start_preset && i_start_select_drum)
        |=> o_address == 15'h4001) else $error("drum preset wrong");
    a_shift_down: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_address_register_clear && !i_start_preset && i_shift_count_strobe && set_mask == 15'h0000)
        |=> o_address[6:0] == $past(o_address[6:0]) - 7'h01 && o_address[14:7] == $past(o_address[14:7]))
        else $error("shift count wrong");
    a_fault_sticky: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_storage_class == 5'h01 |=> o_class_fault) else $error("fault missed");
    a_send_pak: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_program_counter_set == (i_to_program_counter_strobe ? o_address : 15'h0000)) else $error("pak send");
    a_send_x: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_to_exchange_strobe |-> o_exchange_set == 15'h0000) else $error("exchange leak");
    a_gate_need: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_first_operand_load_strobe && !i_second_operand_load_strobe && !i_program_counter_load_strobe
        && !i_start_preset && !i_address_register_clear && !i_shift_count_strobe) |=> $stable(o_address))
        else $error("load without strobe");

    // first operand gate alone merges its ones into the old address
    a_load_first: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_address_register_clear && !i_start_preset && !i_shift_count_strobe && i_first_operand_load_strobe
        && !i_program_counter_load_strobe && !i_second_operand_load_strobe)
        |=> o_address == ($past(o_address) | $past(i_first_operand_counter))) else $error("first load");

    // second operand gate alone merges its ones into the old address
    a_load_second: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_address_register_clear && !i_start_preset && !i_shift_count_strobe && i_second_operand_load_strobe
        && !i_program_counter_load_strobe && !i_first_operand_load_strobe)
        |=> o_address == ($past(o_address) | $past(i_second_operand_counter))) else $error("second load");

    // core preset gives the first core address
    a_preset_core: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_address_register_clear && i_start_preset && !i_start_select_drum)
        |=> o_address == 15'h0000) else $error("core preset wrong");

    // two lowest octal groups decode as core
    a_class_core: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_address[14:9] <= 6'h01 |-> o_storage_class == 5'h02) else $error("core class wrong");

    // leading digit one decodes as Q
    a_class_q: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_address[14:12] == 3'h1 |-> o_storage_class == 5'h08) else $error("q class wrong");

    // leading digit two decodes as accumulator
    a_class_acc: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_address[14:12] == 3'h2 |-> o_storage_class == 5'h10) else $error("acc class wrong");

    // upper half of the space decodes as drum
    a_class_drum: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_address[14] |-> o_storage_class == 5'h04) else $error("drum class wrong");

    // the two gaps decode as unassigned
    a_class_gap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_address[14:12] == 3'h3 || (o_address[14:12] == 3'h0 && o_address[14:9] > 6'h01))
        |-> o_storage_class == 5'h01) else $error("gap class wrong");

    // once raised the fault stays until reset
    a_fault_holds: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_class_fault |=> o_class_fault) else $error("fault dropped");

    // no fault rises while the class is legal
    a_fault_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!o_class_fault && o_storage_class != 5'h01) |=> !o_class_fault) else $error("false fault");

    // exchange send shows the address while its strobe is high
    a_send_x_val: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_to_exchange_strobe |-> o_exchange_set == o_address) else $error("exchange value");

    // the shift counter view is the low stages of the address
    a_shift_view: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_shift_counter == o_address[6:0]) else $error("shift view");
endmodule : sar_storage_address_register

// *** testbench/sar_counter_model.sv ***
`timescale 1ns/1ns
module sar_counter_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // set-only ones from the register
    input wire logic [14:0] i_set,
    // counter value seen by the register
    output logic [14:0] o_program_address_counter
);
    // the counter only gains ones; it relies on being cleared first
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_program_address_counter <= 15'h0000;
        end else begin
            o_program_address_counter <= o_program_address_counter | i_set;
        end
    end
endmodule : sar_counter_model

// *** testbench/sar_storage_address_register_bench.sv ***
`timescale 1ns/1ns
module sar_storage_address_register_bench;
    logic i_clock = 0, i_rst_n = 0, drum = 0;
    // strobes: clear, pc, first, second, preset, shift, to pc, to exchange
    logic [7:0] s = 0;
    logic [14:0] u = 0, v = 0, pac, a, ps, xs;
    logic [6:0] sh;
    logic [4:0] c;
    logic f;
    int fail_count = 0, comparisons = 0;
    sar_storage_address_register sar_storage_address_register_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_program_address_counter(pac), .i_first_operand_counter(u), .i_second_operand_counter(v),
        .i_program_counter_load_strobe(s[1]), .i_first_operand_load_strobe(s[2]),
        .i_second_operand_load_strobe(s[3]), .i_address_register_clear(s[0]), .i_start_preset(s[4]),
        .i_start_select_drum(drum), .i_shift_count_strobe(s[5]), .i_to_program_counter_strobe(s[6]),
        .i_to_exchange_strobe(s[7]), .o_address(a), .o_program_counter_set(ps), .o_exchange_set(xs),
        .o_shift_counter(sh), .o_storage_class(c), .o_class_fault(f));
    sar_counter_model sar_counter_model_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_set(ps),
        .o_program_address_counter(pac));
    initial forever #4 i_clock = ~i_clock;
    task check(input string n, input logic [14:0] seen, input logic [14:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    // one-cycle strobe, then let the result land
    task pulse(input logic [7:0] p);
        @(posedge i_clock) s <= p;
        @(posedge i_clock) s <= 8'h00;
        #1;
    endtask : pulse
    task print_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    task t_load;
        @(posedge i_clock) begin u <= 15'h1234; v <= 15'h0421; end
        pulse(8'h01); pulse(8'h04);
        check("first load", a, 15'h1234);
        pulse(8'h08);
        check("or without clear", a, 15'h1635);
        pulse(8'h05);
        check("clear wins", a, 15'h0000);
        $display("load done");
    endtask : t_load
    task t_send;
        pulse(8'h04);
        @(posedge i_clock) s <= 8'hC0;
        #1;
        check("pc send", ps, 15'h1234);
        check("exchange send", xs, 15'h1234);
        pulse(8'h00);
        check("send idle", xs, 15'h0000);
        pulse(8'h01); pulse(8'h02);
        check("round trip", a, 15'h1234);
        $display("send done");
    endtask : t_send
    task t_preset_shift;
        @(posedge i_clock) drum <= 1'b1;
        pulse(8'h10);
        check("drum preset", a, 15'h4001);
        check("drum class", c, 15'h0004);
        @(posedge i_clock) drum <= 1'b0;
        pulse(8'h10);
        check("core preset", a, 15'h0000);
        pulse(8'h20);
        check("shift wrap", a, 15'h007F);
        check("shift out", sh, 15'h007F);
        $display("preset done");
    endtask : t_preset_shift
    task t_class;
        @(posedge i_clock) u <= 15'h1000;
        pulse(8'h01); pulse(8'h04);
        check("q class", c, 15'h0008);
        @(posedge i_clock) u <= 15'h0400;
        pulse(8'h01); pulse(8'h04);
        check("none class", c, 15'h0001);
        pulse(8'h01);
        check("fault holds", f, 15'h0001);
        $display("class done");
    endtask : t_class
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst_n <= 1'b1;
        #1;
        check("reset addr", a, 15'h0000);
        check("reset fault", f, 15'h0000);
        t_load; t_send; t_preset_shift; t_class;
        print_verdict;
    end
    // tests take well under a hundred cycles
    initial begin
        #4000;
        fail_count++;
        print_verdict;
    end
endmodule : sar_storage_address_register_bench
